//--- rtl/asr_host_ctrl.sv
`timescale 1ns/1ps
module asr_host_ctrl (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        reqValid,
  input  wire logic                        reqWrite,
  input  wire logic [asr_pkg::ADDR_W-1:0]  reqAddr,
  input  wire logic [asr_pkg::DATA_W-1:0]  reqWdata,
  output logic                             reqReady,
  output logic                             rspValid,
  output logic      [asr_pkg::DATA_W-1:0]  rspRdata,
  output logic      [asr_pkg::ADDR_W-1:0]  addressLines,
  output logic                             chipOnLowN,
  output logic                             chipOnHigh,
  output logic                             outEnableN,
  output logic                             writeStrobeN,
  input  wire logic [asr_pkg::DATA_W-1:0]  dataLinesIn,
  output logic      [asr_pkg::DATA_W-1:0]  dataLinesOut,
  output logic                             dataLinesOe
);

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  if (asr_pkg::READ_WAIT_CYC >= (1 << asr_pkg::CNT_W))
    $error("Read wait does not fit the timer counter.");
  if (asr_pkg::STORE_PULSE_CYC < asr_pkg::DATA_SETUP_CYC)
    $error("Store pulse shorter than data setup.");

  // ****************************************************************
  // State and registers.
  // ****************************************************************
  asr_pkg::asr_state_t              state_ff;
  logic [asr_pkg::ADDR_W-1:0]       addr_ff;
  logic [asr_pkg::DATA_W-1:0]       wdata_ff;
  logic [asr_pkg::DATA_W-1:0]       rdata_ff;
  logic                             rspValid_ff;
  logic                             select_ff;
  logic                             outEnN_ff;
  logic                             strobeN_ff;
  logic                             dataOe_ff;
  logic [asr_pkg::DATA_W-1:0]       dqSync1_ff;
  logic [asr_pkg::DATA_W-1:0]       dqSync2_ff;
  logic [asr_pkg::CNT_W-1:0]        loadCount;
  logic                             loadTimer;
  logic                             accept;
  asr_timer_if                      tif ();

  asr_timer u_timer (
    .mclk (mclk),
    .rstn (rstn),
    .tif  (tif)
  );

  // Timer hookup.
  assign tif.load  = loadTimer;
  assign tif.count = loadCount;

  // New requests are taken only from idle.
  assign reqReady = (state_ff == asr_pkg::ST_IDLE);
  assign accept   = reqReady && reqValid;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  // Chooses the timer load for each state entry.
  always_comb
  begin
    loadTimer = 1'b0;
    loadCount = '0;
    unique case (state_ff)
      asr_pkg::ST_IDLE:
      begin
        loadTimer = accept;
        loadCount = reqWrite ? asr_pkg::CNT_W'(asr_pkg::RELEASE_CYC)
                             : asr_pkg::CNT_W'(asr_pkg::READ_WAIT_CYC);
      end
      asr_pkg::ST_WRFLOAT:
      begin
        loadTimer = tif.done;
        loadCount = asr_pkg::CNT_W'(asr_pkg::STORE_PULSE_CYC);
      end
      asr_pkg::ST_RDWAIT, asr_pkg::ST_WRPULSE:
      begin
        loadTimer = tif.done;
        loadCount = asr_pkg::CNT_W'(1);
      end
      asr_pkg::ST_RDEND, asr_pkg::ST_WREND:
      begin
        loadTimer = 1'b0;
        loadCount = '0;
      end
    endcase
  end

  // Moves through the read and write sequences.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_ff <= asr_pkg::ST_IDLE;
    else
    begin
      unique case (state_ff)
        asr_pkg::ST_IDLE:
          if (accept)
            state_ff <= reqWrite ? asr_pkg::ST_WRFLOAT
                                 : asr_pkg::ST_RDWAIT;
        asr_pkg::ST_RDWAIT:
          if (tif.done)
            state_ff <= asr_pkg::ST_RDEND;
        asr_pkg::ST_RDEND:
          if (tif.done)
            state_ff <= asr_pkg::ST_IDLE;
        asr_pkg::ST_WRFLOAT:
          if (tif.done)
            state_ff <= asr_pkg::ST_WRPULSE;
        asr_pkg::ST_WRPULSE:
          if (tif.done)
            state_ff <= asr_pkg::ST_WREND;
        asr_pkg::ST_WREND:
          if (tif.done)
            state_ff <= asr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers.
  // ****************************************************************
  // Address and write data are latched on accept and held to idle.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      addr_ff  <= '0;
      wdata_ff <= '0;
    end
    else if (accept)
    begin
      addr_ff  <= reqAddr;
      wdata_ff <= reqWdata;
    end
  end

  // Select rises on the same edge that latches the address.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      select_ff <= 1'b0;
    else if (accept)
      select_ff <= 1'b1;
    else if ((state_ff == asr_pkg::ST_RDEND ||
              state_ff == asr_pkg::ST_WREND) && tif.done)
      select_ff <= 1'b0;
  end

  // Output enable low only in reads; high through writes.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      outEnN_ff <= 1'b1;
    else if (accept)
      outEnN_ff <= reqWrite;
    else if (state_ff == asr_pkg::ST_RDEND && tif.done)
      outEnN_ff <= 1'b1;
  end

  // Strobe falls after the float wait and rises after the pulse.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      strobeN_ff <= 1'b1;
    else if (state_ff == asr_pkg::ST_WRFLOAT && tif.done)
      strobeN_ff <= 1'b0;
    else if (state_ff == asr_pkg::ST_WRPULSE && tif.done)
      strobeN_ff <= 1'b1;
  end

  // Write data goes out with the strobe and stays past its end.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      dataOe_ff <= 1'b0;
    else if (state_ff == asr_pkg::ST_WRFLOAT && tif.done)
      dataOe_ff <= 1'b1;
    else if (state_ff == asr_pkg::ST_WREND && tif.done)
      dataOe_ff <= 1'b0;
  end

  assign addressLines = addr_ff;
  assign chipOnLowN   = !select_ff;
  assign chipOnHigh   = select_ff;
  assign outEnableN   = outEnN_ff;
  assign writeStrobeN = strobeN_ff;
  assign dataLinesOut = wdata_ff;
  assign dataLinesOe  = dataOe_ff;

  // ****************************************************************
  // Read capture.
  // ****************************************************************
  // Two stages bring the data pins into the clock domain.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      dqSync1_ff <= '0;
      dqSync2_ff <= '0;
    end
    else
    begin
      dqSync1_ff <= dataLinesIn;
      dqSync2_ff <= dqSync1_ff;
    end
  end

  // Samples once access and sync delay have both passed.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rdata_ff    <= '0;
      rspValid_ff <= 1'b0;
    end
    else
    begin
      rspValid_ff <= (state_ff == asr_pkg::ST_RDWAIT) && tif.done;
      if ((state_ff == asr_pkg::ST_RDWAIT) && tif.done)
        rdata_ff <= dqSync2_ff;
    end
  end

  assign rspValid = rspValid_ff;
  assign rspRdata = rdata_ff;

endmodule : asr_host_ctrl

//--- rtl/asr_pkg.sv
package asr_pkg;

  // ****************************************************************
  // Memory geometry.
  // ****************************************************************
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // ****************************************************************
  // Timing figures in nanoseconds, and the clock period.
  // ****************************************************************
  localparam int CLK_PERIOD_NS         = 10;
  localparam int READ_CYCLE_NS         = 12;
  localparam int ADDRESS_TO_DATA_NS    = 12;
  localparam int DRIVE_TO_DATA_NS      = 6;
  localparam int RELEASE_NS            = 6;
  localparam int WRITE_CYCLE_NS        = 12;
  localparam int STORE_PULSE_WIDTH_NS  = 10;
  localparam int DATA_SETUP_TO_END_NS  = 6;

  // Least times round up to whole cycles, never below one.
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  // Sampling takes the access time plus two synchroniser stages.
  localparam int SYNC_STAGES      = 2;
  localparam int READ_WAIT_CYC    = ceil_cyc(ADDRESS_TO_DATA_NS)
                                    + SYNC_STAGES;
  localparam int RELEASE_CYC      = ceil_cyc(RELEASE_NS);
  localparam int STORE_PULSE_CYC  = ceil_cyc(STORE_PULSE_WIDTH_NS);
  localparam int DATA_SETUP_CYC   = ceil_cyc(DATA_SETUP_TO_END_NS);
  localparam int READ_CYCLE_CYC   = ceil_cyc(READ_CYCLE_NS);
  localparam int WRITE_CYCLE_CYC  = ceil_cyc(WRITE_CYCLE_NS);
  localparam int CNT_W            = 4;

  // ****************************************************************
  // Controller states.
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b00_0001,
    ST_RDWAIT  = 6'b00_0010,
    ST_RDEND   = 6'b00_0100,
    ST_WRFLOAT = 6'b00_1000,
    ST_WRPULSE = 6'b01_0000,
    ST_WREND   = 6'b10_0000
  } asr_state_t;

endpackage : asr_pkg

//--- rtl/asr_timer_if.sv
`timescale 1ns/1ps
// Carries a load request and a done flag between controller and timer.
interface asr_timer_if;
  logic                       load;
  logic [asr_pkg::CNT_W-1:0]  count;
  logic                       done;
  modport ctrl  (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface : asr_timer_if

//--- rtl/asr_timer.sv
`timescale 1ns/1ps
module asr_timer (
  input  wire logic  mclk,
  input  wire logic  rstn,
  asr_timer_if.timer tif
);

  // ****************************************************************
  // Down counter; done is high while the count has run out.
  // ****************************************************************
  logic [asr_pkg::CNT_W-1:0] cnt_ff;

  // Load restarts the count, otherwise it falls to zero and stays.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      cnt_ff <= '0;
    else if (tif.load)
      cnt_ff <= tif.count;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - 1'b1;
  end

  // Done follows the count only, so the controller may load on done
  // without closing a loop through load; the controller qualifies it by
  // state.
  assign tif.done = (cnt_ff == '0);

endmodule : asr_timer

//--- bench/asr_host_ctrl_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Pin timing checks on the memory controller.
// ****************************************************************
module asr_host_ctrl_sva (
  input wire logic                        mclk,
  input wire logic                        rstn,
  input wire logic                        reqValid,
  input wire logic                        reqWrite,
  input wire logic                        reqReady,
  input wire logic                        rspValid,
  input wire logic [asr_pkg::ADDR_W-1:0]  addressLines,
  input wire logic                        chipOnLowN,
  input wire logic                        chipOnHigh,
  input wire logic                        outEnableN,
  input wire logic                        writeStrobeN,
  input wire logic [asr_pkg::DATA_W-1:0]  dataLinesOut,
  input wire logic                        dataLinesOe
);
  // All checks run on the one clock and rest during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_sel_pair: assert property (chipOnHigh == !chipOnLowN)
    else $error("selects disagree");
  a_read_no_strobe: assert property (!outEnableN |-> writeStrobeN)
    else $error("strobe low in read");
  a_write_oe_off: assert property (!writeStrobeN |-> outEnableN)
    else $error("output enable on in write");
  a_write_selected: assert property (!writeStrobeN |-> !chipOnLowN)
    else $error("strobe without select");
  a_strobe_width: assert property ($fell(writeStrobeN)
    |-> !writeStrobeN[*2])
    else $error("strobe pulse short");
  a_data_setup: assert property ($rose(writeStrobeN) |-> dataLinesOe
    && $past(dataLinesOe) && $stable(dataLinesOut))
    else $error("write data not set up");
  a_addr_write: assert property (!writeStrobeN || $rose(writeStrobeN)
    |-> $stable(addressLines))
    else $error("address moved in write");
  a_read_cycle: assert property ($fell(outEnableN)
    |=> $stable(addressLines)[*2])
    else $error("read cycle short");
  a_read_answer: assert property ($fell(outEnableN)
    |-> ##[4:6] rspValid)
    else $error("read answer late");
  a_rsp_in_read: assert property (rspValid |-> !outEnableN)
    else $error("answer outside read");
  a_no_contend: assert property (dataLinesOe |-> outEnableN
    && $past(outEnableN))
    else $error("data driven while memory on");
  // Main scenarios reached.
  c_read: cover property (reqValid && reqReady && !reqWrite);
  c_answer: cover property ($rose(rspValid));
  c_write: cover property ($fell(writeStrobeN));
endmodule : asr_host_ctrl_sva

bind asr_host_ctrl asr_host_ctrl_sva asr_host_ctrl_sva_i (.mclk(mclk),
  .rstn(rstn), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqReady(reqReady), .rspValid(rspValid), .addressLines(addressLines),
  .chipOnLowN(chipOnLowN), .chipOnHigh(chipOnHigh),
  .outEnableN(outEnableN), .writeStrobeN(writeStrobeN),
  .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));

//--- bench/asr_sram_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Behavioural byte-wide static memory on the far side.
// ****************************************************************
module asr_sram_model (
  input  wire logic [asr_pkg::ADDR_W-1:0]  addr,
  input  wire logic                        selLowN,
  input  wire logic                        selHigh,
  input  wire logic                        outEnN,
  input  wire logic                        strobeN,
  input  wire logic                        slowMode,
  input  wire logic [asr_pkg::DATA_W-1:0]  dataIn,
  output logic      [asr_pkg::DATA_W-1:0]  dataOut
);
  logic [asr_pkg::DATA_W-1:0]  mem [0:(1<<asr_pkg::ADDR_W)-1];
  logic                        sel;
  logic                        wrOn;
  logic                        rdOn;
  // Both selects must be active; a low strobe keeps the outputs off.
  assign sel = !selLowN && selHigh;
  assign wrOn = sel && !strobeN;
  assign rdOn = sel && !outEnN && strobeN;
  initial dataOut = 8'h00;
  // The byte is stored when select and strobe stop overlapping.
  always @(negedge wrOn) mem[addr] = dataIn;
  // Old data lingers, then is invalid, then the byte shows; released
  // lines show the inverse of their last value.
  always @(addr or rdOn)
  begin
    if (!rdOn)
      dataOut <= #6 ~dataOut;
    else
    begin
      dataOut <= #4 ~mem[addr];
      dataOut <= #(slowMode ? 12 : 5) mem[addr];
    end
  end
endmodule : asr_sram_model

//--- bench/tb_asr_host_ctrl.sv
`timescale 1ns/1ps
// ****************************************************************
// Testbench for the memory controller.
// ****************************************************************
module tb_asr_host_ctrl;
  logic                        mclk, rstn, reqValid, reqWrite, slowMode;
  logic                        reqReady, rspValid, chipOnLowN, chipOnHigh;
  logic                        outEnableN, writeStrobeN, dataLinesOe;
  logic [asr_pkg::ADDR_W-1:0]  reqAddr, addressLines;
  logic [asr_pkg::DATA_W-1:0]  reqWdata, rspRdata, dataLinesOut;
  logic [asr_pkg::DATA_W-1:0]  memOut, dataWire, q;
  int                          err_count, n_tests;
  // The data pins carry whichever side has its driver on.
  assign dataWire = dataLinesOe ? dataLinesOut : memOut;
  asr_host_ctrl asr_host_ctrl_i (.mclk(mclk), .rstn(rstn),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .addressLines(addressLines),
    .chipOnLowN(chipOnLowN), .chipOnHigh(chipOnHigh),
    .outEnableN(outEnableN), .writeStrobeN(writeStrobeN),
    .dataLinesIn(dataWire), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe));
  asr_sram_model asr_sram_model_i (.addr(addressLines),
    .selLowN(chipOnLowN), .selHigh(chipOnHigh), .outEnN(outEnableN),
    .strobeN(writeStrobeN), .slowMode(slowMode), .dataIn(dataWire),
    .dataOut(memOut));
  // Compares one value and logs a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Idle pins: selects off, enables off, host not driving, ready.
  task automatic chk_idle();
    chk({2'b00, chipOnLowN, chipOnHigh, outEnableN, writeStrobeN,
         dataLinesOe, reqReady}, 8'h2d);
  endtask : chk_idle
  // Hands one request over and, for a read, collects the answer.
  task automatic xfer(input logic wr, input logic [12:0] a,
                      input logic [7:0] d);
    int i;
    i = 0;
    q = 8'hxx;
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqWdata <= d;
    do @(posedge mclk); while (reqReady !== 1'b1 && ++i < 20);
    reqValid <= 1'b0;
    // A request never taken within the limit counts as a mismatch.
    chk({7'h00, reqReady}, 8'h01);
    for (i = 0; i < 12 && !wr; i++)
    begin
      @(posedge mclk);
      if (rspValid === 1'b1)
      begin
        q = rspRdata;
        break;
      end
    end
  endtask : xfer
  // Back-to-back writes at both ends of the address range.
  task automatic t_edges();
    xfer(1'b1, 13'h0000, 8'ha5);
    xfer(1'b1, 13'h1fff, 8'h5a);
    xfer(1'b0, 13'h0000, 8'h00);
    chk(q, 8'ha5);
    xfer(1'b0, 13'h1fff, 8'h00);
    chk(q, 8'h5a);
  endtask : t_edges
  // Overwrite, then read back from a slow memory.
  task automatic t_slow();
    xfer(1'b1, 13'h0aaa, 8'h3c);
    xfer(1'b1, 13'h0aaa, 8'hc3);
    slowMode <= 1'b1;
    xfer(1'b0, 13'h0aaa, 8'h00);
    chk(q, 8'hc3);
    slowMode <= 1'b0;
  endtask : t_slow
  // Reset cut into a read leaves the pins idle and the memory intact.
  task automatic t_mid_reset();
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= 1'b0;
    @(posedge mclk);
    reqValid <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk_idle();
    @(posedge mclk);
    rstn <= 1'b1;
    xfer(1'b0, 13'h1fff, 8'h00);
    chk(q, 8'h5a);
  endtask : t_mid_reset
  // Ends the run with the verdict.
  task automatic final_report();
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Clock at 100 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    #20000;
    err_count++;
    final_report();
  end
  // Main sequence.
  initial
  begin
    {rstn, reqValid, reqWrite, slowMode} = 4'h0;
    reqAddr = 13'h0000;
    reqWdata = 8'h00;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    #1 chk_idle();
    t_edges();
    t_slow();
    t_mid_reset();
    final_report();
  end
endmodule : tb_asr_host_ctrl
